// ### bench/ptc_pin_model.sv
// Behavioural model of the external event or pulse source on one counter pin
`timescale 1ns/1ps
module ptc_pin_model (
	input wire logic ref_clk,
	output logic     pin
);
	initial pin = 1'b0;

	// ==========================================================
	// Stimulus tasks, all changes right after a rising edge
	task automatic set(input logic lvl);
		@(posedge ref_clk) pin <= lvl;
	endtask

	// Level lvl for n cycles, then the opposite level
	task automatic pulse(input logic lvl, input int n);
		@(posedge ref_clk) pin <= lvl;
		repeat (n) @(posedge ref_clk);
		pin <= ~lvl;
	endtask
endmodule // ptc_pin_model

// ### bench/pulse_width_timer_counter_test.sv
// Self-checking testbench of the timer/counter block over APB
`timescale 1ns/1ps
`include "ptc_consts.svh"
module pulse_width_timer_counter_test;
	logic        ref_clk = 1'b0;
	logic        reset   = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [11:0] paddr   = 12'h000;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pb;
	logic        pw;
	logic        irq;
	logic        wake;
	logic [31:0] v;
	logic        e;
	int          checks     = 0;
	int          mismatches = 0;
	int          wakes      = 0;
	int          w0;

	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (wake === 1'b1) wakes++;

	ptc_top ptc_top_i (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .byte_counter_pin(pb), .word_counter_input(pw), .irq(irq),
		.wake(wake));
	ptc_pin_model pb_i (.ref_clk(ref_clk), .pin(pb));
	ptc_pin_model pw_i (.ref_clk(ref_clk), .pin(pw));

	// ==========================================================
	// APB master and comparison tasks
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] rd_v, output logic err);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge ref_clk) penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd_v = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] dummy;
		logic        derr;
		xfer(1'b1, idx, d, dummy, derr);
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 8'h00, v, e);
		cmp(v, exp);
	endtask

	// Read with an allowed window, for counts that depend on divider phase
	task automatic cr(input logic [7:0] idx, input logic [31:0] lo, input logic [31:0] hi);
		xfer(1'b0, idx, 8'h00, v, e);
		cmp({31'h0, v >= lo && v <= hi}, 32'h1);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		test_done();
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		rc(`PTC_IDX_BCTL, 32'h08);
		rc(`PTC_IDX_WCTL, 32'h08);
		xfer(1'b0, 8'h30, 8'h00, v, e);
		cmp({31'h0, e}, 32'h1);
		cmp(v, 32'h0);
		// Byte timer overflow with a preload change while running
		wr(`PTC_IDX_MASK, 8'h01);
		wr(`PTC_IDX_BVAL, 8'hf0);
		rc(`PTC_IDX_BVAL, 32'hf0);
		wr(`PTC_IDX_BCTL, 8'h90);
		wr(`PTC_IDX_BVAL, 8'h20);
		cr(`PTC_IDX_BVAL, 32'hf0, 32'hff);
		for (int i = 0; i < 200 && irq !== 1'b1; i++) @(posedge ref_clk);
		cmp({31'h0, irq}, 32'h1);
		rc(`PTC_IDX_BCTL, 32'h90);
		rc(`PTC_IDX_STAT, 32'h1);
		cr(`PTC_IDX_BVAL, 32'h20, 32'h26);
		wr(`PTC_IDX_BCTL, 8'h80);
		wr(`PTC_IDX_STAT, 8'h01);
		repeat (2) @(posedge ref_clk);
		cmp({31'h0, irq}, 32'h0);
		// Time base of four system clocks per count
		wr(`PTC_IDX_BVAL, 8'h00);
		wr(`PTC_IDX_BCTL, 8'h90);
		repeat (40) @(posedge ref_clk);
		wr(`PTC_IDX_BCTL, 8'h80);
		cr(`PTC_IDX_BVAL, 32'd10, 32'd11);
		w0 = v;
		repeat (20) @(posedge ref_clk);
		rc(`PTC_IDX_BVAL, w0);
		// Word counter: buffered preload, masked overflow still wakes
		wr(`PTC_IDX_WLO, 8'hfe);
		wr(`PTC_IDX_WHI, 8'hff);
		rc(`PTC_IDX_WHI, 32'hff);
		rc(`PTC_IDX_WLO, 32'hfe);
		w0 = wakes;
		wr(`PTC_IDX_WCTL, 8'h90);
		repeat (24) @(posedge ref_clk);
		rc(`PTC_IDX_STAT, 32'h2);
		cmp({31'h0, irq}, 32'h0);
		cmp({31'h0, wakes > w0}, 32'h1);
		wr(`PTC_IDX_WCTL, 8'h80);
		wr(`PTC_IDX_STAT, 8'h02);
		// Pulse width: level at arming ignored, rising start, single shot
		wr(`PTC_IDX_BVAL, 8'h00);
		pb_i.set(1'b1);
		wr(`PTC_IDX_BCTL, 8'hd8);
		repeat (20) @(posedge ref_clk);
		rc(`PTC_IDX_BVAL, 32'h0);
		pb_i.set(1'b0);
		repeat (8) @(posedge ref_clk);
		pb_i.pulse(1'b1, 40);
		repeat (10) @(posedge ref_clk);
		rc(`PTC_IDX_BCTL, 32'hc8);
		rc(`PTC_IDX_BVAL, 32'd10);
		w0 = v;
		pb_i.pulse(1'b1, 40);
		repeat (10) @(posedge ref_clk);
		rc(`PTC_IDX_BVAL, w0);
		// Falling start with the edge bit clear
		wr(`PTC_IDX_BVAL, 8'h00);
		pb_i.set(1'b1);
		wr(`PTC_IDX_BCTL, 8'hd0);
		pb_i.pulse(1'b0, 20);
		repeat (10) @(posedge ref_clk);
		rc(`PTC_IDX_BCTL, 32'hc0);
		rc(`PTC_IDX_BVAL, 32'd5);
		// Pulse mode overflow reloads and flags: three ticks from fe
		wr(`PTC_IDX_BVAL, 8'hfe);
		wr(`PTC_IDX_BCTL, 8'hd8);
		pb_i.set(1'b0);
		repeat (4) @(posedge ref_clk);
		pb_i.pulse(1'b1, 12);
		repeat (10) @(posedge ref_clk);
		cmp({31'h0, irq}, 32'h1);
		rc(`PTC_IDX_STAT, 32'h1);
		rc(`PTC_IDX_BVAL, 32'hff);
		rc(`PTC_IDX_BCTL, 32'hc8);
		wr(`PTC_IDX_STAT, 8'h01);
		// Event counting of falling edges on the byte pin
		wr(`PTC_IDX_BVAL, 8'h00);
		wr(`PTC_IDX_BCTL, 8'h58);
		for (int i = 0; i < 2; i++) begin
			pb_i.pulse(1'b1, 4);
			repeat (4) @(posedge ref_clk);
		end
		repeat (6) @(posedge ref_clk);
		rc(`PTC_IDX_BVAL, 32'h2);
		// Event counting of rising edges on the word pin
		wr(`PTC_IDX_WLO, 8'h00);
		wr(`PTC_IDX_WHI, 8'h00);
		wr(`PTC_IDX_WCTL, 8'h50);
		for (int i = 0; i < 3; i++) begin
			pw_i.pulse(1'b1, 4);
			repeat (4) @(posedge ref_clk);
		end
		repeat (6) @(posedge ref_clk);
		rc(`PTC_IDX_WHI, 32'h0);
		rc(`PTC_IDX_WLO, 32'h3);
		test_done();
	end
endmodule // pulse_width_timer_counter_test

// ### pkg/ptc_cnt_if.sv
// Control and status link between the register block and one counter unit
`timescale 1ns/1ps
interface ptc_cnt_if #(parameter int W = 8);
	logic [1:0]   mode;
	logic         run;
	logic         edge_sel;
	logic         tick;
	logic         read_hold;
	logic         preload_wr;
	logic [W-1:0] preload_val;
	logic [W-1:0] count;
	logic [W-1:0] preload;
	logic         ovf;
	logic         done;

	modport ctl (
		output mode, run, edge_sel, tick, read_hold, preload_wr, preload_val,
		input  count, preload, ovf, done
	);
	modport unit (
		input  mode, run, edge_sel, tick, read_hold, preload_wr, preload_val,
		output count, preload, ovf, done
	);
endinterface

// ### pkg/ptc_consts.svh
// Register indices, field positions, reset values and rates of the timer/counter block
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

// ==========================================================
// Register indices (byte address = 4 * index)
`define PTC_IDX_BVAL 8'h0d
`define PTC_IDX_BCTL 8'h0e
`define PTC_IDX_WHI  8'h0f
`define PTC_IDX_WLO  8'h10
`define PTC_IDX_WCTL 8'h11
`define PTC_IDX_STAT 8'h20
`define PTC_IDX_MASK 8'h21

// ==========================================================
// Control register fields
`define PTC_BIT_MODE_HI 7
`define PTC_BIT_MODE_LO 6
`define PTC_BIT_RUN     4
`define PTC_BIT_EDGE    3
`define PTC_CTL_RST     8'h08
`define PTC_CTL_USED    8'hd8

// ==========================================================
// Mode field codes
`define PTC_MODE_EVENT 2'h1
`define PTC_MODE_TIMER 2'h2
`define PTC_MODE_PULSE 2'h3

// ==========================================================
// Internal time base: system clock divided by this
`define PTC_TICK_DIV 4

`endif

// ### pkg/ptc_pkg.sv
// Types shared by the timer/counter modules
package ptc_pkg;

	typedef enum logic [1:0] {PTC_PW_IDLE, PTC_PW_MEASURE, PTC_PW_HELD} ptc_pw_type;

	typedef struct packed {
		logic [7:0]  ctl_byte;
		logic [7:0]  ctl_word;
		logic [7:0]  low_buf;
		logic [1:0]  status;
		logic [1:0]  mask;
		logic [31:0] rdata;
		logic [1:0]  div;
	} ptc_top_state_type;

endpackage

// ### rtl/ptc_counter.sv
// One count-up timer/event counter unit with preload and pulse-width capture
`timescale 1ns/1ps
`include "ptc_consts.svh"
module ptc_counter import ptc_pkg::*; #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pin,
	ptc_cnt_if.unit  bus
);

	typedef struct packed {
		logic         sync1;
		logic         sync2;
		logic         prev;
		ptc_pw_type   pw;
		logic [W-1:0] cnt;
		logic [W-1:0] preload;
		logic         ovf;
		logic         done;
	} ptc_cnt_state_type;

	ptc_cnt_state_type s;
	ptc_cnt_state_type next_s;
	logic              rise;
	logic              fall;
	logic              start;
	logic              stop;
	logic              inc;

	if (W < 8 || W > 16) begin : g_bad_width
		$error("ptc_counter: width must be 8 to 16");
	end

	// ==========================================================
	// Next state
	always_comb begin
		next_s = s;
		// Two stages before any edge logic looks at the pin
		next_s.sync1 = pin; // see RULE_16
		next_s.sync2 = s.sync1;
		next_s.prev = s.sync2;
		next_s.ovf = 1'b0;
		next_s.done = 1'b0;
		rise = s.sync2 & ~s.prev;
		fall = ~s.sync2 & s.prev;
		start = bus.edge_sel ? rise : fall; // see RULE_01
		stop = bus.edge_sel ? fall : rise;
		inc = 1'b0;

		// Only a fresh edge arms the count, never a level already present
		case (s.pw)
			PTC_PW_IDLE: begin
				if (bus.run && bus.mode == `PTC_MODE_PULSE && start) begin // see RULE_03
					next_s.pw = PTC_PW_MEASURE;
				end
			end
			PTC_PW_MEASURE: begin
				if (!bus.run || bus.mode != `PTC_MODE_PULSE) begin
					next_s.pw = PTC_PW_IDLE;
				end else if (stop) begin
					next_s.pw = PTC_PW_HELD; // see RULE_01
					next_s.done = 1'b1;
				end
			end
			PTC_PW_HELD: begin
				// Result is frozen until software sets run again
				if (!bus.run) begin // see RULE_02
					next_s.pw = PTC_PW_IDLE;
				end
			end
			default: next_s.pw = PTC_PW_IDLE;
		endcase

		case (bus.mode) // see RULE_12
			`PTC_MODE_EVENT: inc = bus.run && (bus.edge_sel ? fall : rise); // see RULE_05
			`PTC_MODE_TIMER: inc = bus.run && bus.tick; // see RULE_13
			`PTC_MODE_PULSE: inc = bus.run && bus.tick && s.pw == PTC_PW_MEASURE;
			default: inc = 1'b0;
		endcase
		// A read in progress blocks the count, so events may be lost
		if (bus.read_hold) begin // see RULE_11
			inc = 1'b0;
		end

		if (inc && (&s.cnt)) begin
			next_s.cnt = s.preload; // see RULE_14
			next_s.ovf = 1'b1; // see RULE_04
		end else if (inc) begin
			next_s.cnt = s.cnt + 1'b1;
		end

		if (bus.preload_wr) begin
			next_s.preload = bus.preload_val; // see RULE_10
			if (!bus.run) begin
				next_s.cnt = bus.preload_val; // see RULE_09
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign bus.count = s.cnt;
	assign bus.preload = s.preload;
	assign bus.ovf = s.ovf;
	assign bus.done = s.done;

endmodule // ptc_counter

// ### rtl/ptc_top.sv
// APB register block with 8-bit and 16-bit timer/event counters and overflow interrupt
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ptc_consts.svh"

// Behaviour
// RULE_01: pulse mode counts between chosen edge and return
// RULE_02: finished measurement holds until run set again
// RULE_03: only an edge starts pulse measurement
// RULE_04: pulse mode overflow reloads and flags
// RULE_05: counting only while run bit is set
// RULE_06: run self-clears only after pulse measurement
// RULE_07: any overflow is a wake-up source
// RULE_08: cleared enable blocks the overflow interrupt
// RULE_09: preload write while stopped loads counter too
// RULE_10: preload write while running waits for reload
// RULE_11: counter read blocks its count clock
// RULE_12: mode field selects event, timer, pulse
// RULE_13: timer and pulse modes use clock/4
// RULE_14: count to all ones, reload, set flag
// RULE_15: word low byte buffered until high write
// RULE_16: pin inputs synchronised before edge detection
// RULE_17: one 8-bit and one 16-bit unit
module ptc_top import ptc_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        byte_counter_pin,
	input  wire logic        word_counter_input,
	output logic             irq,
	output logic             wake
);

	ptc_top_state_type s;
	ptc_top_state_type next_s;
	logic [7:0]        idx;
	logic              aligned;
	logic              hit;
	logic [31:0]       rmux;
	logic              acc_wr;
	logic              rd_setup;
	logic              wr_bval;
	logic              wr_bctl;
	logic              wr_whi;
	logic              wr_wlo;
	logic              wr_wctl;
	logic              wr_stat;
	logic              wr_mask;
	logic [1:0]        w1c;

	ptc_cnt_if #(.W(8))  b0();
	ptc_cnt_if #(.W(16)) b1();

	// ==========================================================
	// APB decode
	assign idx = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign acc_wr = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign wr_bval = acc_wr && hit && idx == `PTC_IDX_BVAL;
	assign wr_bctl = acc_wr && hit && idx == `PTC_IDX_BCTL;
	assign wr_whi = acc_wr && hit && idx == `PTC_IDX_WHI;
	assign wr_wlo = acc_wr && hit && idx == `PTC_IDX_WLO;
	assign wr_wctl = acc_wr && hit && idx == `PTC_IDX_WCTL;
	assign wr_stat = acc_wr && hit && idx == `PTC_IDX_STAT;
	assign wr_mask = acc_wr && hit && idx == `PTC_IDX_MASK;

	always_comb begin
		rmux = 32'h0;
		hit = aligned;
		case (idx)
			`PTC_IDX_BVAL: rmux[7:0] = b0.count;
			`PTC_IDX_BCTL: rmux[7:0] = s.ctl_byte & `PTC_CTL_USED;
			`PTC_IDX_WHI:  rmux[7:0] = b1.count[15:8];
			`PTC_IDX_WLO:  rmux[7:0] = s.low_buf;
			`PTC_IDX_WCTL: rmux[7:0] = s.ctl_word & `PTC_CTL_USED;
			`PTC_IDX_STAT: rmux[1:0] = s.status;
			`PTC_IDX_MASK: rmux[1:0] = s.mask;
			default:       hit = 1'b0;
		endcase
		if (!aligned) begin
			rmux = 32'h0;
		end
	end

	// ==========================================================
	// Register state
	always_comb begin
		next_s = s;
		next_s.div = s.div + 2'h1; // see RULE_13
		w1c = wr_stat ? pwdata[1:0] : 2'h0;

		// Read data is captured in the setup cycle; the count is frozen meanwhile
		if (rd_setup) begin
			next_s.rdata = hit ? rmux : 32'h0;
			if (hit && idx == `PTC_IDX_WHI) begin
				next_s.low_buf = b1.count[7:0];
			end
		end
		if (wr_wlo) begin
			next_s.low_buf = pwdata[7:0]; // see RULE_15
		end
		if (wr_bctl) begin
			next_s.ctl_byte = pwdata[7:0] & `PTC_CTL_USED;
		end else if (b0.done && b0.mode == `PTC_MODE_PULSE) begin
			next_s.ctl_byte[`PTC_BIT_RUN] = 1'b0; // see RULE_01
		end
		if (wr_wctl) begin
			next_s.ctl_word = pwdata[7:0] & `PTC_CTL_USED;
		end else if (b1.done && b1.mode == `PTC_MODE_PULSE) begin
			next_s.ctl_word[`PTC_BIT_RUN] = 1'b0; // see RULE_06
		end
		if (wr_mask) begin
			next_s.mask = pwdata[1:0];
		end
		// A new overflow beats a clear in the same cycle
		next_s.status = (s.status & ~w1c) | {b1.ovf, b0.ovf}; // see RULE_14
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s <= '{ctl_byte: `PTC_CTL_RST, ctl_word: `PTC_CTL_RST, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Counter units
	assign b0.mode = s.ctl_byte[`PTC_BIT_MODE_HI:`PTC_BIT_MODE_LO];
	assign b0.run = s.ctl_byte[`PTC_BIT_RUN];
	assign b0.edge_sel = s.ctl_byte[`PTC_BIT_EDGE];
	assign b0.tick = s.div == 2'(`PTC_TICK_DIV - 1);
	assign b0.read_hold = psel && !pwrite && hit && idx == `PTC_IDX_BVAL; // see RULE_11
	assign b0.preload_wr = wr_bval;
	assign b0.preload_val = pwdata[7:0];

	assign b1.mode = s.ctl_word[`PTC_BIT_MODE_HI:`PTC_BIT_MODE_LO];
	assign b1.run = s.ctl_word[`PTC_BIT_RUN];
	assign b1.edge_sel = s.ctl_word[`PTC_BIT_EDGE];
	assign b1.tick = s.div == 2'(`PTC_TICK_DIV - 1);
	assign b1.read_hold = psel && !pwrite && hit && idx == `PTC_IDX_WHI;
	assign b1.preload_wr = wr_whi; // see RULE_15
	assign b1.preload_val = {pwdata[7:0], s.low_buf};

	ptc_counter #(.W(8)) u_byte ( // see RULE_17
		.ref_clk (ref_clk),
		.reset   (reset),
		.pin     (byte_counter_pin),
		.bus     (b0)
	);

	ptc_counter #(.W(16)) u_word (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pin     (word_counter_input),
		.bus     (b1)
	);

	// ==========================================================
	// Outputs
	assign prdata = s.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign irq = |(s.status & s.mask); // see RULE_08
	// Wake fires whether or not the interrupt is enabled
	assign wake = b0.ovf | b1.ovf; // see RULE_07

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	chk_stopped_holds: assert property ( // see RULE_05
		!b0.run && !b0.preload_wr |=> $stable(b0.count)
	) else $error("byte counter moved while stopped");

	chk_pulse_autoclr: assert property ( // see RULE_01
		b1.done && b1.mode == `PTC_MODE_PULSE && !wr_wctl |=>
			!s.ctl_word[`PTC_BIT_RUN] && !b1.done
	) else $error("run bit not cleared after measurement");

	chk_run_no_selfclr: assert property ( // see RULE_06
		b0.run && b0.mode != `PTC_MODE_PULSE && !wr_bctl |=> b0.run
	) else $error("run bit cleared outside pulse mode");

	chk_irq_masked: assert property ( // see RULE_08
		s.mask == 2'h0 |-> !irq
	) else $error("interrupt raised while disabled");

	chk_ovf_reload: assert property ( // see RULE_14
		b0.ovf |-> $past(b0.count) == 8'hff && b0.count == $past(b0.preload) ##1 s.status[0]
	) else $error("overflow did not reload and flag");

	chk_idle_load: assert property ( // see RULE_09
		wr_whi && !b1.run |=> b1.count == {$past(pwdata[7:0]), $past(s.low_buf)}
	) else $error("stopped counter not loaded by preload write");

	chk_busy_load: assert property ( // see RULE_10
		wr_bval && b0.run && b0.count != 8'hff |=>
			b0.count == $past(b0.count) || b0.count == $past(b0.count) + 8'h1
	) else $error("running counter overwritten by preload write");

	chk_read_freeze: assert property ( // see RULE_11
		b1.read_hold && !b1.preload_wr |=> $stable(b1.count)
	) else $error("counter advanced during read");

	chk_low_buffered: assert property ( // see RULE_15
		wr_wlo |=> $stable(b1.preload)
	) else $error("low byte write reached preload");

	chk_timer_rate: assert property ( // see RULE_13
		b0.mode == `PTC_MODE_TIMER && b0.run && !b0.tick && !b0.preload_wr |=> $stable(b0.count)
	) else $error("timer advanced off the time base");

	chk_wake_ovf: assert property ( // see RULE_07
		b1.ovf |-> wake ##1 s.status[1]
	) else $error("word overflow did not wake and flag");

	cov_pulse_done: cover property (b0.done ##1 !b0.run);
	cov_word_ovf: cover property (b1.ovf ##1 irq);
	cov_event_ovf: cover property (b0.mode == `PTC_MODE_EVENT && b0.ovf);
	cov_clear_race: cover property (wr_stat && pwdata[0] && b0.ovf);

endmodule // ptc_top
